/* File: hdl/rwi_consts.svh */
// register offsets, field positions, reset values and timing counts
`ifndef RWI_CONSTS_SVH
`define RWI_CONSTS_SVH
// printed offsets are not multiples of four: index, byte address is 4x
`define RWI_IDX_FLAGS 17'h1FFF0
`define RWI_IDX_IRQ 17'h1FFF6
`define RWI_IDX_DOG 17'h1FFF7
`define RWI_ADDR_W 19
// event_flags fields
`define RWI_F_WDF 7
`define RWI_F_AF 6
`define RWI_F_PF 5
`define RWI_F_OSCF 4
// irq_setup fields
`define RWI_I_WIE 7
`define RWI_I_AIE 6
`define RWI_I_PFE 5
`define RWI_I_HL 3
`define RWI_I_PL 2
// dog_control fields
`define RWI_D_STROBE 7
`define RWI_D_LOCK 6
// reset values
`define RWI_IRQ_RST 8'h08
`define RWI_FLAGS_RST 8'h00
// timing
`define RWI_CLK_HZ 20000000
`define RWI_PULSE_MS 200
`define RWI_PULSE_CYC ((`RWI_CLK_HZ / 1000) * `RWI_PULSE_MS)
`define RWI_RECALL_MS 20
`define RWI_RECALL_CYC ((`RWI_CLK_HZ / 1000) * `RWI_RECALL_MS)
`define RWI_OSC_DIV 1024
`endif

/* File: hdl/rwi_pkg.sv */
// types shared by the supervisory logic
package rwi_pkg;
   typedef enum logic [1:0] {
      RWI_OFF = 2'b00,
      RWI_RECALL = 2'b01,
      RWI_RUN = 2'b11
   } rwi_pwr_t;
endpackage

/* File: hdl/rwi_dog_tick.sv */
// 32 Hz watchdog tick divided from the oscillator tick
`timescale 1ns/10ps
`include "rwi_consts.svh"
module rwi_dog_tick
   import rwi_pkg::*;
#(
   parameter int DIV = `RWI_OSC_DIV
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic osc_tick,
   output logic tick_32hz
);
   typedef struct packed {
      logic [9:0] cnt;
      logic tick;
   } rwi_tick_t;
   rwi_tick_t st_reg, st_next;

   // ==========================================
   // divider
   // a stopped oscillator gives no osc_tick, so no tick either
   always_comb begin
      st_next = st_reg;
      st_next.tick = 1'b0;
      if (osc_tick) begin
         if (st_reg.cnt == 10'(DIV - 1)) begin
            st_next.cnt = 10'h000;
            st_next.tick = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 10'h001;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tick_32hz = st_reg.tick;

   a_tick_needs_osc: assert property (@(posedge pclk) disable iff (!presetn)
      tick_32hz |-> $past(osc_tick))
      else $error("tick without oscillator tick");
endmodule

/* File: hdl/rwi_supervisor.sv */
// watchdog, power monitor and interrupt merge behind an APB slave
//
// What this block does
// - watchdog counts down once per 32 Hz tick, only with oscillator running.
// - at power up stored timeout loads into counter, counting starts at once.
// - writing strobe one reloads counter and restarts, avoiding timeout.
// - counter reaching zero sets watchdog flag and, if enabled, interrupt.
// - timeout bits accept writes only while write lock is zero.
// - timeout value zero disables the watchdog completely.
// - watchdog enable gates timeout onto interrupt; flag sets regardless.
// - flags read clears watchdog flag and its interrupt.
// - supply below threshold starts a store and switches to backup.
// - on backup, host access blocked; data back after recall delay.
// - interrupt only when a source flag is set and its enable is one.
// - alarm enable gates alarm match onto interrupt; flag sets whatever the enable, but only on normal supply.
// - power-fail enable gates monitor onto interrupt; flag sets unless a flags read clears it in the same cycle.
// - polarity one is active high push-pull, zero active low open drain.
// - pulse select one gives a fixed 200 ms active pulse.
// - pulse select zero holds active until flags or control read.
// - flags read clears the flags it reported and the output, cutting a pulse short.
// - no interrupts on backup supply; an active open-drain output stays low for the first backup clock.
// - alarm match sets the alarm match flag.
// - at reset all flags clear, oscillator-failed bit included.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`include "rwi_consts.svh"
module rwi_supervisor
   import rwi_pkg::*;
#(
   parameter int PULSE_CYC = `RWI_PULSE_CYC,
   parameter int RECALL_CYC = `RWI_RECALL_CYC,
   parameter logic [5:0] STORED_TIMEOUT = 6'h00
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`RWI_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic osc_tick,
   input wire logic osc_running,
   input wire logic osc_failed,
   input wire logic alarm_match,
   input wire logic supply_ok,
   output logic store_start,
   output logic on_backup,
   output logic host_access_ok,
   output logic irq_out,
   output logic irq_oe
);
   typedef struct packed {
      rwi_pwr_t pwr;
      logic [31:0] recall_cnt;
      logic [7:0] flags;
      logic [7:0] irq_setup;
      logic [5:0] timeout;
      logic lock;
      logic [5:0] count;
      logic active;
      logic [31:0] pulse_cnt;
      logic store;
      logic [31:0] rdata;
      logic src_prev;
   } rwi_state_t;
   rwi_state_t st_reg, st_next;
   logic tick_32hz;
   logic acc, setup, wr, rd, hit_flags, hit_irq, hit_dog, mapped;
   logic dog_fire, src_irq, normal;
   logic [16:0] idx;

   // ==========================================
   // tick divider
   rwi_dog_tick #(.DIV(`RWI_OSC_DIV)) u_tick (
      .pclk(pclk),
      .presetn(presetn),
      .osc_tick(osc_tick),
      .tick_32hz(tick_32hz)
   );

   // index from byte address; low two bits are dropped
   function automatic logic is_reg(input logic [16:0] a,
                                   input logic [16:0] r);
      return a == r;
   endfunction

   // ==========================================
   // bus decode
   // zero wait states; unmapped access answers pslverr
   assign idx = paddr[`RWI_ADDR_W-1:2];
   assign acc = psel && penable;
   assign setup = psel && !penable && !pwrite;
   assign hit_flags = is_reg(idx, `RWI_IDX_FLAGS);
   assign hit_irq = is_reg(idx, `RWI_IDX_IRQ);
   assign hit_dog = is_reg(idx, `RWI_IDX_DOG);
   assign mapped = hit_flags || hit_irq || hit_dog;
   assign normal = st_reg.pwr == RWI_RUN;
   // host is locked out on backup and during recall
   assign wr = acc && pwrite && mapped && normal && pstrb[0];
   assign rd = acc && !pwrite && mapped && normal;
   assign pready = 1'b1;
   assign pslverr = acc && (!mapped || !normal);
   assign prdata = st_reg.rdata;

   // ==========================================
   // watchdog expiry and interrupt sources
   assign dog_fire = normal && tick_32hz && osc_running
      && st_reg.timeout != 6'h00
      && st_reg.count == 6'h01;
   assign src_irq = (st_reg.flags[`RWI_F_WDF]
         && st_reg.irq_setup[`RWI_I_WIE])
      || (st_reg.flags[`RWI_F_AF] && st_reg.irq_setup[`RWI_I_AIE])
      || (st_reg.flags[`RWI_F_PF]
         && st_reg.irq_setup[`RWI_I_PFE]);

   // ==========================================
   // next state
   always_comb begin
      st_next = st_reg;
      st_next.store = 1'b0;
      st_next.rdata = 32'h00000000;
      // edge memory, so a held flag does not fire the output again
      st_next.src_prev = src_irq && normal;
      // read data captured in setup so it stands through the access phase
      if (acc) begin
         st_next.rdata = st_reg.rdata;
      end else if (setup && hit_flags) begin
         st_next.rdata = {24'h000000, st_reg.flags};
      end else if (setup && hit_irq) begin
         st_next.rdata = {24'h000000, st_reg.irq_setup};
      end else if (setup && hit_dog) begin
         st_next.rdata = {24'h000000, 1'b0, st_reg.lock, st_reg.timeout};
      end
      // power monitor
      case (st_reg.pwr)
         RWI_OFF: begin
            if (supply_ok) begin
               st_next.pwr = RWI_RECALL;
               st_next.recall_cnt = 32'h00000000;
            end
         end
         RWI_RECALL: begin
            if (!supply_ok) begin
               st_next.pwr = RWI_OFF;
            end else if (st_reg.recall_cnt == 32'(RECALL_CYC - 1)) begin
               st_next.pwr = RWI_RUN;
            end else begin
               st_next.recall_cnt = st_reg.recall_cnt + 32'h00000001;
            end
         end
         RWI_RUN: begin
            if (!supply_ok) begin
               st_next.pwr = RWI_OFF;
               st_next.store = 1'b1;
               st_next.flags[`RWI_F_PF] = 1'b1;
            end
         end
         default: st_next.pwr = RWI_OFF;
      endcase
      // watchdog counter keeps time only with oscillator running
      if (tick_32hz && osc_running && st_reg.timeout != 6'h00) begin
         if (st_reg.count <= 6'h01) begin
            st_next.count = st_reg.timeout; // free running reload
         end else begin
            st_next.count = st_reg.count - 6'h01;
         end
      end
      // flags read clears the reported flags, then new events still set
      // only flags already reported are cleared; a power-fail set in the read cycle is lost
      if (rd && hit_flags) begin
         st_next.flags = st_reg.flags & ~st_reg.rdata[7:0];
         st_next.active = 1'b0;
         st_next.pulse_cnt = 32'h00000000;
         st_next.src_prev = 1'b0;
      end
      if (rd && hit_irq) begin
         if (!st_reg.irq_setup[`RWI_I_PL]) begin
            st_next.active = 1'b0;
         end
      end
      if (wr && hit_irq) begin
         st_next.irq_setup = pwdata[7:0] & 8'hEC;
      end
      if (wr && hit_dog) begin
         st_next.lock = pwdata[`RWI_D_LOCK];
         if (!pwdata[`RWI_D_LOCK] && !st_reg.lock) begin
            st_next.timeout = pwdata[5:0];
         end
         if (pwdata[`RWI_D_STROBE]) begin
            st_next.count = (!pwdata[`RWI_D_LOCK] && !st_reg.lock)
               ? pwdata[5:0] : st_reg.timeout;
         end
      end
      // watchdog, alarm and oscillator-failed sets win over the read clear
      if (dog_fire && !(wr && hit_dog && pwdata[`RWI_D_STROBE])) begin
         st_next.flags[`RWI_F_WDF] = 1'b1;
      end
      if (alarm_match && normal) begin
         st_next.flags[`RWI_F_AF] = 1'b1;
      end
      st_next.flags[`RWI_F_OSCF] = st_next.flags[`RWI_F_OSCF] | osc_failed;
      // output driver: level holds, pulse times out
      if (!normal) begin
         st_next.active = 1'b0;
      end else if (src_irq && !st_reg.src_prev && !st_reg.active
            && !(rd && hit_flags)) begin
         st_next.active = 1'b1;
         st_next.pulse_cnt = 32'h00000000;
      end else if (st_reg.active && st_reg.irq_setup[`RWI_I_PL]) begin
         if (st_reg.pulse_cnt == 32'(PULSE_CYC - 1)) begin
            st_next.active = 1'b0;
         end else begin
            st_next.pulse_cnt = st_reg.pulse_cnt + 32'h00000001;
         end
      end
   end

   // ==========================================
   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
         st_reg.irq_setup <= `RWI_IRQ_RST;
         st_reg.flags <= `RWI_FLAGS_RST;
         st_reg.timeout <= STORED_TIMEOUT;
         st_reg.count <= STORED_TIMEOUT;
      end else begin
         st_reg <= st_next;
      end
   end

   // ==========================================
   // pin driver
   // active high drives both levels; active low only pulls down
   always_comb begin
      if (st_reg.irq_setup[`RWI_I_HL]) begin
         irq_out = st_reg.active && normal;
         irq_oe = 1'b1; // pulls low on backup rather than floating
      end else begin
         irq_out = 1'b0;
         irq_oe = st_reg.active;
      end
   end
   assign store_start = st_reg.store;
   assign on_backup = st_reg.pwr == RWI_OFF;
   assign host_access_ok = normal;

   // ==========================================
   // checks
   sequence s_flags_read;
      rd && hit_flags;
   endsequence
   sequence s_idle_after;
      !st_reg.active [*1];
   endsequence

   a_wdf_on_fire: assert property (@(posedge pclk) disable iff (!presetn)
      dog_fire |=> st_reg.flags[`RWI_F_WDF])
      else $error("watchdog flag not set");
   a_zero_disables: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.timeout == 6'h00 |-> !dog_fire)
      else $error("disabled watchdog fired");
   a_lock_holds: assert property (@(posedge pclk) disable iff (!presetn)
      wr && hit_dog && st_reg.lock |=> $stable(st_reg.timeout))
      else $error("locked timeout changed");
   a_strobe_reload: assert property (@(posedge pclk) disable iff (!presetn)
      wr && hit_dog && pwdata[`RWI_D_STROBE] && st_reg.lock
      |=> st_reg.count == $past(st_reg.timeout))
      else $error("strobe did not reload");
   a_read_clears: assert property (@(posedge pclk) disable iff (!presetn)
      s_flags_read |=> s_idle_after)
      else $error("flags read left output active");
   a_no_backup_irq: assert property (@(posedge pclk) disable iff (!presetn)
      !normal |=> !st_reg.active)
      else $error("interrupt while on backup");
   a_irq_needs_src: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(st_reg.active) |-> $past(src_irq))
      else $error("interrupt without enabled source");
   a_store_on_fail: assert property (@(posedge pclk) disable iff (!presetn)
      normal && !supply_ok |=> store_start && on_backup)
      else $error("no store on supply loss");
   a_level_holds: assert property (@(posedge pclk) disable iff (!presetn)
      st_reg.active && !st_reg.irq_setup[`RWI_I_PL] && normal && !rd
      && supply_ok |=> st_reg.active)
      else $error("level interrupt dropped");
   a_open_drain: assert property (@(posedge pclk) disable iff (!presetn)
      !st_reg.irq_setup[`RWI_I_HL] |-> irq_out == 1'b0)
      else $error("open drain drove high");
endmodule

/* File: tb/rwi_host_side.sv */
// far-side model: crystal tick source and the pulled-up interrupt pin
`timescale 1ns/10ps
module rwi_host_side
   import rwi_pkg::*;
(
   input wire logic pclk,
   input wire logic run,
   input wire logic irq_out,
   input wire logic irq_oe,
   output logic osc_tick,
   output wire logic int_pin
);
   // a stopped crystal gives no ticks, so the watchdog has to stall
   initial osc_tick = 1'b0;
   always @(posedge pclk) begin
      osc_tick <= run & ~osc_tick;
   end
   // undriven open-drain pin rests at the pull-up level
   assign int_pin = irq_oe ? irq_out : 1'b1;
endmodule

/* File: tb/rwi_supervisor_test.sv */
// self-checking bench for the supervisory logic
`timescale 1ns/10ps
`include "rwi_consts.svh"
module rwi_supervisor_test
   import rwi_pkg::*;
;
   // short counts keep the run brief
   localparam int PULSE = 20;
   localparam int RECALL = 10;
   localparam logic [16:0] FLG = `RWI_IDX_FLAGS;
   localparam logic [16:0] IRQ = `RWI_IDX_IRQ;
   localparam logic [16:0] DOG = `RWI_IDX_DOG;
   logic pclk, presetn, psel, penable, pwrite, osc_running, osc_failed;
   logic alarm_match, supply_ok, pready, pslverr, osc_tick, store_start;
   logic on_backup, host_access_ok, irq_out, irq_oe, int_pin, hl, err;
   logic [18:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb;
   logic [7:0] rd;
   int mismatches, comparisons, n;

   rwi_supervisor #(.PULSE_CYC(PULSE), .RECALL_CYC(RECALL),
      .STORED_TIMEOUT(6'h01)) i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .osc_tick(osc_tick), .osc_running(osc_running),
      .osc_failed(osc_failed), .alarm_match(alarm_match),
      .supply_ok(supply_ok), .store_start(store_start),
      .on_backup(on_backup), .host_access_ok(host_access_ok),
      .irq_out(irq_out), .irq_oe(irq_oe));
   rwi_host_side i_host (.pclk(pclk), .run(osc_running), .irq_out(irq_out),
      .irq_oe(irq_oe), .osc_tick(osc_tick), .int_pin(int_pin));

   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   // ==========================================================
   // shared tasks
   task final_report();
      if (mismatches == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp, input string m);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t %s: got %h want %h", $time, m, seen, exp);
      end
   endtask
   task bail(input string m);
      mismatches++;
      $display("ERROR %0t timeout %s", $time, m);
      final_report();
   endtask
   // read data stands in the access phase and is taken at its edge
   task apb(input logic wr, input logic [16:0] idx, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) bail("pready");
      err = pslverr;
      rd = prdata[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task set_mode(input logic [7:0] v);
      apb(1'b1, IRQ, v);
      hl = v[`RWI_I_HL];
   endtask
   // active level follows the polarity last programmed
   task wait_act(input logic lvl, input int lim);
      n = 0;
      while ((int_pin ^ ~hl) !== lvl && n < lim) begin
         @(posedge pclk);
         n++;
      end
   endtask
   task wait_up();
      n = 0;
      while (host_access_ok !== 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 100) bail("recall");
   endtask
   task alarm();
      @(posedge pclk);
      alarm_match <= 1'b1;
      @(posedge pclk);
      alarm_match <= 1'b0;
   endtask

   // ==========================================================
   // scenarios
   task t_power_up();
      apb(1'b0, FLG, 8'h00);
      check(err, 1'b1, "early access");
      supply_ok <= 1'b1;
      wait_up();
      check(n >= RECALL - 1, 1'b1, "recall delay");
      apb(1'b0, FLG, 8'h00);
      check(rd, `RWI_FLAGS_RST, "flags reset");
      apb(1'b0, IRQ, 8'h00);
      check(rd, `RWI_IRQ_RST, "setup reset");
      apb(1'b1, IRQ, 8'hFF);
      apb(1'b0, IRQ, 8'h00);
      check(rd, 8'hEC, "setup bits");
      apb(1'b0, 17'h1FFF5, 8'h00);
      check(err, 1'b1, "unmapped");
      set_mode(`RWI_IRQ_RST);
   endtask
   task t_watchdog();
      osc_running <= 1'b1;
      repeat (2200) @(posedge pclk);
      check(int_pin, 1'b0, "enable clear");
      // stop the crystal so no tick lands among the writes
      osc_running <= 1'b0;
      apb(1'b0, FLG, 8'h00);
      check(rd, 8'h80, "timeout flag");
      apb(1'b0, FLG, 8'h00);
      check(rd, 8'h00, "flag cleared");
      apb(1'b1, DOG, 8'h02);
      apb(1'b1, DOG, 8'h42);
      apb(1'b1, DOG, 8'hC5);
      apb(1'b0, DOG, 8'h00);
      check(rd, 8'h42, "locked timeout");
      apb(1'b1, DOG, 8'hC0);
      osc_running <= 1'b1;
      // strobe faster than one tick period keeps the count above zero
      repeat (4) begin
         repeat (1500) @(posedge pclk);
         apb(1'b1, DOG, 8'hC0);
      end
      apb(1'b0, FLG, 8'h00);
      check(rd, 8'h00, "strobe holds off");
      osc_running <= 1'b0;
      apb(1'b1, DOG, 8'h00);
      apb(1'b1, DOG, 8'h00);
      osc_running <= 1'b1;
      repeat (4200) @(posedge pclk);
      apb(1'b0, FLG, 8'h00);
      check(rd, 8'h00, "zero disables");
   endtask
   task t_alarm_level();
      set_mode(8'h48);
      alarm();
      wait_act(1'b1, 20);
      check(n < 20, 1'b1, "alarm irq");
      repeat (30) @(posedge pclk);
      check(int_pin, 1'b1, "level holds");
      apb(1'b0, FLG, 8'h00);
      check(rd, 8'h40, "alarm flag");
      check(int_pin, 1'b0, "level cleared");
      set_mode(8'h40);
      alarm();
      wait_act(1'b1, 20);
      check(int_pin, 1'b0, "active low");
      apb(1'b0, IRQ, 8'h00);
      check(int_pin, 1'b1, "control read");
      apb(1'b0, FLG, 8'h00);
      check(rd, 8'h40, "flag kept");
      set_mode(8'h08);
      alarm();
      wait_act(1'b1, 20);
      check(n, 20, "alarm disabled");
      apb(1'b0, FLG, 8'h00);
      check(rd, 8'h40, "flag only");
   endtask
   task t_pulse();
      set_mode(8'h4C);
      alarm();
      wait_act(1'b1, 20);
      wait_act(1'b0, 100);
      check(n >= PULSE - 1 && n <= PULSE + 1, 1'b1, "pulse width");
      apb(1'b0, FLG, 8'h00);
      check(rd, 8'h40, "pulse flag");
      alarm();
      wait_act(1'b1, 20);
      apb(1'b0, FLG, 8'h00);
      check(int_pin, 1'b0, "pulse cut");
   endtask
   task t_power_fail();
      set_mode(8'h28);
      supply_ok <= 1'b0;
      n = 0;
      while (store_start !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      check(n < 20, 1'b1, "store start");
      repeat (3) @(posedge pclk);
      check(on_backup, 1'b1, "on backup");
      wait_act(1'b1, 30);
      check(n, 30, "no irq on backup");
      apb(1'b0, FLG, 8'h00);
      check(err, 1'b1, "host blocked");
      supply_ok <= 1'b1;
      wait_up();
      check(on_backup, 1'b0, "back on supply");
      wait_act(1'b1, 20);
      check(n < 20, 1'b1, "power fail irq");
      apb(1'b0, FLG, 8'h00);
      check(rd, 8'h20, "power fail flag");
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 19'h00000;
      pwdata = 32'h00000000;
      pstrb = 4'hF;
      osc_running = 1'b0;
      osc_failed = 1'b0;
      alarm_match = 1'b0;
      supply_ok = 1'b0;
      hl = 1'b1;
      mismatches = 0;
      comparisons = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_power_up();
      t_watchdog();
      t_alarm_level();
      t_pulse();
      t_power_fail();
      final_report();
   end
endmodule
